/* File: logic/cpu_address_map_and_fetch.v */
/*
 program counter, fetch control and address map of the 8-bit core.
 assumes a rom array that answers one cycle after the address, a data
 ram outside, and an execution unit that sends one-cycle jump commands.
*/
// What this block does
// RL1 - one 16-bit address space of 64 KB
// RL2 - io registers memory mapped in two regions
// RL3 - read-only byte rom at top, 32K/48K
// RL4 - top 32 bytes hold reset/interrupt vectors
// RL5 - vector call reads table below interrupt vectors
// RL6 - page call targets top 256-byte page
// RL7 - fetch byte from rom at current pc
// RL8 - jump targets wrap, no page boundaries
// RL9 - short jump: opcode address plus two plus d5
// RL10 - byte jump: sign-extended d8 added to pc
// RL11 - absolute jump loads full 16-bit target
// RL12 - constant reads and pc plus accumulator mode
// RL13 - reset loads pc from two top bytes
// RL14 - visible pc is instruction address plus two
// RL15 - data ram from 0x40, 1K or 2K
// RL16 - first 256 addresses directly addressable
// RL17 - banks alias lowest 128 ram bytes, live
// RL18 - fetch from ram causes address-trap reset
// RL19 - reset pin driven low during trap reset
// RL20 - 16 banks of eight bytes, pairs addressable
// RL21 - trap checked on fetch address, before effects
`timescale 1ns/1ps
`include "addr_map_defines.vh"
module cpu_address_map_and_fetch #(
	parameter TRAP_CYCLES = `TRAP_RESET_CYCLES
) (
	input wire core_clk,
	input wire rst_n,
	input wire large_variant,
	input wire [7:0] rom_data,
	input wire fetch_req,
	input wire short_rel_jump,
	input wire byte_rel_jump,
	input wire abs_jump,
	input wire vector_call,
	input wire page_call,
	input wire cond_ok,
	input wire [7:0] jump_disp,
	input wire [15:0] jump_target,
	input wire [3:0] call_index,
	input wire [7:0] page_offset,
	input wire data_rd,
	input wire data_pc_acc,
	input wire [15:0] data_addr,
	input wire [7:0] acc_value,
	input wire bank_we,
	input wire [3:0] bank_sel,
	input wire [2:0] bank_reg,
	input wire [7:0] bank_wdata,
	input wire [7:0] ram_rdata,
	input wire reset_pin_in,
	output reg [15:0] rom_addr,
	output reg [15:0] pc_out,
	output reg [7:0] opcode,
	output reg opcode_valid,
	output reg [7:0] data_rdata,
	output reg data_valid,
	output reg [15:0] pair_value,
	output reg core_reset,
	output reg reset_pin_out,
	output reg reset_pin_oe_n
);
	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	localparam ST_VEC_LO = 3'd0; // read low byte of a vector
	localparam ST_VEC_HI = 3'd1; // read high byte of a vector
	localparam ST_VEC_LD = 3'd2; // combine bytes into pc
	localparam ST_RUN = 3'd3; // normal fetching
	localparam ST_TRAP = 3'd4; // address-trap reset held
	localparam ST_DATA = 3'd5; // data read returns
	localparam ST_FETCH = 3'd6; // fetch returns
	localparam ST_DATA_WAIT = 3'd7; // rom answers a cycle after the address

	reg [2:0] state_q, state_d;
	reg [15:0] pc_q, pc_d; // next fetch address
	reg [15:0] vaddr_q, vaddr_d; // vector being read
	reg [7:0] vlo_q, vlo_d; // low byte latched
	reg [15:0] trap_cnt_q, trap_cnt_d; // trap hold counter
	reg data_bank_q, data_bank_d; // data read came from bank overlay
	reg data_rom_q, data_rom_d; // data read came from rom
	reg boot_q, boot_d; // vector load is a restart, not a vector call
	reg pin_s1_q, pin_s2_q, pin_s3_q; // reset pin synchroniser
	reg pin_low_q; // filtered reset pin level

	wire fetch_rom, fetch_ram, fetch_bank, fetch_sfr, fetch_io2, fetch_dir;
	wire data_is_rom, data_is_ram, data_is_bank, data_is_sfr, data_is_io2, data_is_dir;
	wire [7:0] bank_rdata;
	reg [15:0] data_eff; // effective data address
	reg [6:0] bank_raddr; // bank overlay read index

	// ------------------------------------------------------------
	// decoders
	// ------------------------------------------------------------
	// fetch side decode checks the opcode fetch address itself
	addr_region_decode u_fetch_dec (
		.addr(pc_q),
		.large_variant(large_variant),
		.is_rom(fetch_rom),
		.is_ram(fetch_ram),
		.is_bank(fetch_bank),
		.is_sfr(fetch_sfr),
		.is_io2(fetch_io2),
		.is_direct(fetch_dir)
	);
	// data side decode
	addr_region_decode u_data_dec (
		.addr(data_eff),
		.large_variant(large_variant),
		.is_rom(data_is_rom),
		.is_ram(data_is_ram),
		.is_bank(data_is_bank),
		.is_sfr(data_is_sfr),
		.is_io2(data_is_io2),
		.is_direct(data_is_dir)
	);

	// ------------------------------------------------------------
	// register banks overlaid on ram
	// ------------------------------------------------------------
	// bank index: sel*8 + reg; data reads use low 7 bits past base
	always @* begin
		// table lookups add the accumulator to the visible pc, two ahead
		data_eff = data_pc_acc ? (pc_q + `PREFETCH_AHEAD + {8'h00, acc_value}) : data_addr; // RL12 RL14
		// only a data read steers the overlay port, else the pair select holds it
		bank_raddr = (data_rd && data_is_bank) ? data_eff[6:0] - 7'h40 : {bank_sel, bank_reg}; // RL17
	end

	reg_bank_file #(.AW(7)) u_banks (
		.core_clk(core_clk),
		.we(bank_we),
		.waddr({bank_sel, bank_reg}), // RL20
		.wdata(bank_wdata),
		.raddr(bank_raddr),
		.rdata(bank_rdata)
	);

	// ------------------------------------------------------------
	// reset pin synchroniser, three stages
	// ------------------------------------------------------------
	// external low on the pin also resets the core
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_q <= 1'b1;
			pin_s2_q <= 1'b1;
			pin_s3_q <= 1'b1;
			pin_low_q <= 1'b0;
		end else begin
			pin_s1_q <= reset_pin_in;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			if (pin_s2_q == pin_s3_q) begin
				pin_low_q <= ~pin_s3_q;
			end
		end
	end

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always @* begin
		state_d = state_q;
		pc_d = pc_q;
		vaddr_d = vaddr_q;
		vlo_d = vlo_q;
		trap_cnt_d = trap_cnt_q;
		data_bank_d = data_bank_q;
		data_rom_d = data_rom_q;
		boot_d = boot_q;
		case (state_q)
			ST_VEC_LO: begin
				// rom_addr shows vaddr; data back next cycle
				state_d = ST_VEC_HI;
			end
			ST_VEC_HI: begin
				vlo_d = rom_data;
				state_d = ST_VEC_LD;
			end
			ST_VEC_LD: begin
				pc_d = {rom_data, vlo_q}; // RL13
				state_d = ST_RUN;
			end
			ST_RUN: begin
				if (short_rel_jump && cond_ok) begin
					// displacement counts from the visible pc, two ahead of pc_q
					pc_d = pc_q + `PREFETCH_AHEAD + {11'h000, jump_disp[4:0]}; // RL9 RL8 RL14
				end else if (byte_rel_jump && cond_ok) begin
					pc_d = pc_q + `PREFETCH_AHEAD + {{8{jump_disp[7]}}, jump_disp}; // RL10 RL8
				end else if (abs_jump) begin
					pc_d = jump_target; // RL11
				end else if (vector_call) begin
					vaddr_d = `CALL_VEC_BASE + {11'h000, call_index, 1'b0}; // RL5
					boot_d = 1'b0;
					state_d = ST_VEC_LO;
				end else if (page_call) begin
					pc_d = `PAGE_BASE + {8'h00, page_offset}; // RL6
				end else if (fetch_req) begin
					if (fetch_ram) begin
						// trap before the fetched byte is used
						trap_cnt_d = 16'h0000;
						state_d = ST_TRAP; // RL18 RL21
					end else begin
						state_d = ST_FETCH; // RL7
					end
				end else if (data_rd) begin
					data_bank_d = data_is_bank;
					data_rom_d = data_is_rom;
					state_d = ST_DATA_WAIT; // RL12
				end
			end
			ST_FETCH: begin
				pc_d = pc_q + 16'h0001;
				state_d = ST_RUN;
			end
			ST_DATA_WAIT: begin
				// address is at the array, byte comes next cycle
				state_d = ST_DATA;
			end
			ST_DATA: begin
				state_d = ST_RUN;
			end
			ST_TRAP: begin
				if (trap_cnt_q >= TRAP_CYCLES[15:0] - 16'h0001) begin
					vaddr_d = `RESET_VEC_LO;
					state_d = ST_VEC_LO; // RL13
					boot_d = 1'b1;
				end else begin
					trap_cnt_d = trap_cnt_q + 16'h0001;
				end
			end
			default: begin
				state_d = ST_VEC_LO;
				boot_d = 1'b1;
				vaddr_d = `RESET_VEC_LO;
			end
		endcase
		// external reset pin restarts from the reset vector
		if (pin_low_q && state_q != ST_TRAP) begin
			vaddr_d = `RESET_VEC_LO;
			boot_d = 1'b1;
			state_d = ST_VEC_LO;
		end
	end

	// ------------------------------------------------------------
	// state registers
	// ------------------------------------------------------------
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_VEC_LO;
			pc_q <= 16'h0000;
			vaddr_q <= `RESET_VEC_LO;
			vlo_q <= 8'h00;
			trap_cnt_q <= 16'h0000;
			data_bank_q <= 1'b0;
			data_rom_q <= 1'b0;
			boot_q <= 1'b1;
		end else begin
			state_q <= state_d;
			pc_q <= pc_d;
			vaddr_q <= vaddr_d;
			vlo_q <= vlo_d;
			trap_cnt_q <= trap_cnt_d;
			data_bank_q <= data_bank_d;
			data_rom_q <= data_rom_d;
			boot_q <= boot_d;
		end
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	// rom address: vector bytes, data address or pc
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rom_addr <= `RESET_VEC_LO;
			pc_out <= 16'h0000;
			opcode <= 8'h00;
			opcode_valid <= 1'b0;
			data_rdata <= 8'h00;
			data_valid <= 1'b0;
			pair_value <= 16'h0000;
			core_reset <= 1'b1;
			reset_pin_out <= 1'b0;
			reset_pin_oe_n <= 1'b0;
		end else begin
			if (state_d == ST_VEC_LO) begin
				rom_addr <= vaddr_d;
			end else if (state_d == ST_VEC_HI) begin
				rom_addr <= vaddr_q + 16'h0001; // RL4
			end else if (state_d == ST_DATA_WAIT) begin
				rom_addr <= data_eff; // RL1
			end else if (state_d == ST_DATA) begin
				// hold the data address while the array answers
				rom_addr <= rom_addr;
			end else begin
				rom_addr <= pc_d; // RL7
			end
			pc_out <= pc_q + `PREFETCH_AHEAD; // RL14
			opcode_valid <= (state_q == ST_FETCH);
			if (state_q == ST_FETCH) begin
				opcode <= rom_data;
			end
			data_valid <= (state_q == ST_DATA);
			// live bank contents win over the ram array; overlay byte lands a cycle early
			if (state_q == ST_DATA_WAIT && data_bank_q) begin
				data_rdata <= bank_rdata; // RL17
			end else if (state_q == ST_DATA && !data_bank_q) begin
				data_rdata <= data_rom_q ? rom_data : ram_rdata; // RL12
			end
			pair_value <= {pair_value[7:0], bank_rdata}; // RL20
			// a vector call walks the same states but must not reset the core
			core_reset <= (boot_d && ((state_d == ST_VEC_LO) || (state_d == ST_VEC_HI) ||
				(state_d == ST_VEC_LD))) || (state_d == ST_TRAP);
			reset_pin_out <= 1'b0;
			reset_pin_oe_n <= (state_d != ST_TRAP); // RL19
		end
	end
endmodule

/* File: include/addr_map_defines.vh */
/*
 address map, vector table locations, timing counts for the fetch and
 address-map block. assumes nothing; definitions only.
*/
`ifndef ADDR_MAP_DEFINES_VH
`define ADDR_MAP_DEFINES_VH
// ------------------------------------------------------------
// address regions
// ------------------------------------------------------------
`define ROM_BASE_SMALL 16'h8000
`define ROM_BASE_LARGE 16'h4000
`define RAM_BASE 16'h0040
`define RAM_END_SMALL 16'h043F
`define RAM_END_LARGE 16'h083F
`define BANK_END 16'h00BF
`define SFR_END 16'h003F
`define DIRECT_END 16'h00FF
`define IO2_BASE 16'h0F80
`define IO2_END 16'h0FFF
// ------------------------------------------------------------
// vector tables at the top of program memory
// ------------------------------------------------------------
`define RESET_VEC_HI 16'hFFFF
`define RESET_VEC_LO 16'hFFFE
`define INT_VEC_BASE 16'hFFE0
`define CALL_VEC_BASE 16'hFFC0
`define PAGE_BASE 16'hFF00
// ------------------------------------------------------------
// pc behaviour and timing
// ------------------------------------------------------------
`define PREFETCH_AHEAD 16'h0002
`define TRAP_RESET_NS 1000
`define CLK_PERIOD_NS 40
`define TRAP_RESET_CYCLES ((`TRAP_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: logic/reg_bank_file.v */
/*
 general register banks: 16 banks of 8 bytes overlaid on low ram.
 assumes a single writer port and registered read data.
*/
`timescale 1ns/1ps
module reg_bank_file #(
	parameter AW = 7
) (
	input wire core_clk,
	input wire we,
	input wire [AW-1:0] waddr,
	input wire [7:0] wdata,
	input wire [AW-1:0] raddr,
	output reg [7:0] rdata
);
	// ------------------------------------------------------------
	// storage, no reset: contents are unstable at power up
	// ------------------------------------------------------------
	reg [7:0] mem [0:(1<<AW)-1];
	// write and registered read on one edge; a same-address read returns the old byte
	always @(posedge core_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

/* File: logic/addr_region_decode.v */
/*
 pure address decoder for the 64 KB space.
 assumes the variant select is stable during operation.
*/
`timescale 1ns/1ps
`include "addr_map_defines.vh"
module addr_region_decode (
	input wire [15:0] addr,
	input wire large_variant,
	output wire is_rom,
	output wire is_ram,
	output wire is_bank,
	output wire is_sfr,
	output wire is_io2,
	output wire is_direct
);
	// ------------------------------------------------------------
	// region compares
	// ------------------------------------------------------------
	wire [15:0] rom_base = large_variant ? `ROM_BASE_LARGE : `ROM_BASE_SMALL;
	wire [15:0] ram_end = large_variant ? `RAM_END_LARGE : `RAM_END_SMALL;
	assign is_rom = (addr >= rom_base); // RL3
	assign is_ram = (addr >= `RAM_BASE) && (addr <= ram_end); // RL15
	assign is_bank = (addr >= `RAM_BASE) && (addr <= `BANK_END); // RL17
	assign is_sfr = (addr <= `SFR_END); // RL2
	assign is_io2 = (addr >= `IO2_BASE) && (addr <= `IO2_END); // RL2
	assign is_direct = (addr <= `DIRECT_END); // RL16
endmodule

/* File: test/cpu_address_map_and_fetch_monitor.sv */
/*
 port checker for the fetch and address-map block.
 assumes it is bound to the top module, one clock domain.
*/
`timescale 1ns/1ps
module cpu_address_map_and_fetch_monitor #(
	parameter TRAP_CYCLES = 2
) (
	input wire core_clk,
	input wire rst_n,
	input wire fetch_req,
	input wire short_rel_jump,
	input wire byte_rel_jump,
	input wire abs_jump,
	input wire cond_ok,
	input wire [7:0] jump_disp,
	input wire [15:0] jump_target,
	input wire data_rd,
	input wire [15:0] pc_out,
	input wire opcode_valid,
	input wire data_valid,
	input wire core_reset,
	input wire reset_pin_out,
	input wire reset_pin_oe_n
);
// ----
// helper logic
// ----
reg [15:0] tgt_q; // opcode address a taken jump should land on
reg [7:0] cnt_q; // cycles the reset pin has been pulled low
wire jmp = short_rel_jump | byte_rel_jump | abs_jump;
wire [15:0] tgt_d = short_rel_jump ? pc_out + {11'h000, jump_disp[4:0]} :
	byte_rel_jump ? pc_out + {{8{jump_disp[7]}}, jump_disp} : jump_target;
// capture only on a jump, so later inputs cannot disturb it
always @(posedge core_clk) begin
	if (jmp)
		tgt_q <= tgt_d;
end
// count the pin-low run; cleared as soon as the pin is released
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n)
		cnt_q <= 8'h00;
	else if (!reset_pin_oe_n)
		cnt_q <= cnt_q + 8'h01;
	else
		cnt_q <= 8'h00;
end
// ----
// properties
// ----
default clocking cb @(posedge core_clk); endclocking
default disable iff (!rst_n);
property p_fetch; fetch_req && !core_reset |-> ##[1:3] (opcode_valid || core_reset); endproperty
a_fetch: assert property (p_fetch) else $error("no answer to fetch");
property p_short; short_rel_jump && cond_ok && !core_reset |-> ##[1:3] pc_out == tgt_q + 16'h0002; endproperty
a_short: assert property (p_short) else $error("short jump target off");
property p_byte; byte_rel_jump && cond_ok && !core_reset |-> ##[1:3] pc_out == tgt_q + 16'h0002; endproperty
a_byte: assert property (p_byte) else $error("byte jump target off");
property p_abs; abs_jump && !core_reset |-> ##[1:3] pc_out == tgt_q + 16'h0002; endproperty
a_abs: assert property (p_abs) else $error("absolute jump target off");
property p_hold; (short_rel_jump || byte_rel_jump) && !cond_ok && !core_reset |=> $stable(pc_out) [*3]; endproperty
a_hold: assert property (p_hold) else $error("pc moved on false condition");
property p_data; data_rd && !core_reset |-> ##3 data_valid; endproperty
a_data: assert property (p_data) else $error("no answer to data read");
property p_pin; !reset_pin_oe_n |-> core_reset && !reset_pin_out; endproperty
a_pin: assert property (p_pin) else $error("pin low without core reset");
property p_trap_len; $rose(reset_pin_oe_n) && cnt_q > 8'h01 |-> cnt_q == TRAP_CYCLES; endproperty
a_trap_len: assert property (p_trap_len) else $error("trap length off");
property p_quiet; !reset_pin_oe_n |-> !opcode_valid && !data_valid; endproperty
a_quiet: assert property (p_quiet) else $error("result during trap");
c_fetch: cover property (opcode_valid);
c_jump: cover property (byte_rel_jump && cond_ok);
c_trap: cover property ($rose(reset_pin_oe_n) && cnt_q > 8'h01);
endmodule

/* File: test/mem_model.sv */
/*
 rom and ram arrays on the far side of the fetch block.
 assumes rom_addr is launched from the core clock.
*/
`timescale 1ns/1ps
module mem_model (
	input wire core_clk,
	input wire [15:0] rom_addr,
	output reg [7:0] rom_data,
	output wire [7:0] ram_rdata
);
// ----
// contents: fixed pattern of the address, vectors included
// ----
function [7:0] pat(input [15:0] v);
	pat = v[7:0] ^ {v[14:8], v[15]} ^ 8'h5A;
endfunction
// read-only byte array, data one cycle after the address
always @(posedge core_clk) begin
	rom_data <= pat(rom_addr);
end
// ram answers at once; inverted so it never passes for rom
assign ram_rdata = ~pat(rom_addr);
endmodule

/* File: test/cpu_address_map_and_fetch_tb.sv */
/*
 self-checking bench for the fetch and address-map block.
 assumes mem_model and the checker are compiled before it.
*/
`timescale 1ns/1ps
module cpu_address_map_and_fetch_tb;
localparam TRAP_CYCLES = 2; // short trap keeps the run brief
// ----
// signals
// ----
reg core_clk = 1'b0, rst_n = 1'b0, large_variant = 1'b1, cond_ok = 1'b0, data_pc_acc = 1'b0;
reg [7:0] cmd_v = 8'h00, jump_disp = 8'h00, page_offset = 8'h00, acc_value = 8'h00, bank_wdata = 8'h00;
reg [15:0] jump_target = 16'h0000, data_addr = 16'h0000, pc_m, a;
reg [3:0] call_index = 4'h0, bank_sel = 4'h0;
reg [2:0] bank_reg = 3'h0;
reg [31:0] seed = 32'h8E83; // xorshift state
reg [7:0] d, exp_q[$]; // expected data bytes in order
reg c;
integer error_cnt = 0, samples_checked = 0, i, j, k;
wire bank_we, data_rd, fetch_req, page_call, vector_call, abs_jump, byte_rel_jump, short_rel_jump;
wire [7:0] rom_data, ram_rdata, opcode, data_rdata;
wire [15:0] rom_addr, pc_out, pair_value;
wire opcode_valid, data_valid, core_reset, reset_pin_out, reset_pin_oe_n;
wire reset_pin_in = reset_pin_oe_n ? 1'b1 : reset_pin_out; // pulled up when released
assign {bank_we, data_rd, fetch_req, page_call, vector_call, abs_jump, byte_rel_jump, short_rel_jump} = cmd_v;
always #20 core_clk = ~core_clk;
mem_model mem (.core_clk(core_clk), .rom_addr(rom_addr), .rom_data(rom_data), .ram_rdata(ram_rdata));
cpu_address_map_and_fetch #(.TRAP_CYCLES(TRAP_CYCLES)) DUT (.core_clk(core_clk), .rst_n(rst_n),
	.large_variant(large_variant), .rom_data(rom_data), .fetch_req(fetch_req), .short_rel_jump(short_rel_jump),
	.byte_rel_jump(byte_rel_jump), .abs_jump(abs_jump), .vector_call(vector_call), .page_call(page_call),
	.cond_ok(cond_ok), .jump_disp(jump_disp), .jump_target(jump_target), .call_index(call_index),
	.page_offset(page_offset), .data_rd(data_rd), .data_pc_acc(data_pc_acc), .data_addr(data_addr),
	.acc_value(acc_value), .bank_we(bank_we), .bank_sel(bank_sel), .bank_reg(bank_reg),
	.bank_wdata(bank_wdata), .ram_rdata(ram_rdata), .reset_pin_in(reset_pin_in), .rom_addr(rom_addr),
	.pc_out(pc_out), .opcode(opcode), .opcode_valid(opcode_valid), .data_rdata(data_rdata),
	.data_valid(data_valid), .pair_value(pair_value), .core_reset(core_reset),
	.reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n));
// ----
// model helpers and bus tasks
// ----
function [7:0] mem_b(input [15:0] v);
	mem_b = v[7:0] ^ {v[14:8], v[15]} ^ 8'h5A;
endfunction
function [31:0] xs(input [31:0] v);
	xs = v ^ (v << 13);
	xs = xs ^ (xs >> 17);
	xs = xs ^ (xs << 5);
endfunction
task give_verdict;
	begin
	$display("checks %0d, mismatches %0d", samples_checked, error_cnt);
	if (error_cnt == 0 && samples_checked > 0)
		$display("verification passed");
	else
		$display("verification failed");
	$finish;
	end
endtask
task chk_pc(input [15:0] got, input [15:0] exp);
	begin
	samples_checked++;
	if (got !== exp) begin
		error_cnt++;
		$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
	end
	end
endtask
task chk_byte(input [7:0] got, input [7:0] exp);
	chk_pc({8'h00, got}, {8'h00, exp});
endtask
// one command pulse; all qualifiers launched with it at the edge
task cmd(input integer n, input [15:0] v, input [7:0] b, input f);
	begin
	@(posedge core_clk);
	{jump_target, data_addr, call_index, bank_sel, bank_reg} <= {v, v, v[3:0], v[6:0]};
	{jump_disp, page_offset, acc_value, bank_wdata, cond_ok, data_pc_acc} <= {b, b, b, b, f, f};
	cmd_v <= 8'h01 << n;
	@(posedge core_clk);
	cmd_v <= 8'h00;
	end
endtask
// bounded wait for a result pulse; a hang ends the run
task wait_v(input integer w);
	begin
	k = 0;
	while ((w ? data_valid : opcode_valid) !== 1'b1 && k < 20) begin
		@(posedge core_clk);
		#1;
		k++;
	end
	if (k >= 20) begin
		error_cnt++;
		give_verdict;
	end
	end
endtask
task rd(input [15:0] v, input [7:0] b, input f, input [7:0] e);
	begin
	cmd(6, v, b, f);
	exp_q.push_back(e);
	wait_v(1);
	chk_byte(data_rdata, exp_q.pop_front());
	end
endtask
// wait out a reset, then the pc must hold the reset vector
task boot;
	begin
	k = 0;
	while (core_reset !== 1'b0 && k < 200) begin
		@(posedge core_clk);
		k++;
	end
	if (k >= 200) begin
		error_cnt++;
		give_verdict;
	end
	repeat (3) @(posedge core_clk);
	pc_m = {mem_b(16'hFFFF), mem_b(16'hFFFE)};
	chk_pc(pc_out, pc_m + 16'h0002);
	end
endtask
// ----
// main sequence
// ----
initial begin
	repeat (3) @(posedge core_clk);
	rst_n <= 1'b1;
	boot;
	for (i = 0; i < 8; i++) begin
		seed = xs(seed);
		a = 16'h4000 + seed[15:0] % 16'hB000;
		d = seed[23:16];
		cmd(2, a, d, 1'b0);
		repeat (5) @(posedge core_clk);
		pc_m = a;
		chk_pc(pc_out, pc_m + 16'h0002);
		cmd(5, a, d, 1'b0);
		wait_v(0);
		chk_byte(opcode, mem_b(pc_m));
		pc_m = pc_m + 16'h0001;
		repeat (2) @(posedge core_clk);
		chk_pc(pc_out, pc_m + 16'h0002);
		rd(a, d, 1'b0, mem_b(a));
		rd(a, d, 1'b1, mem_b(pc_m + 16'h0002 + {8'h00, d}));
		rd(16'h0100 + a[9:0], d, 1'b0, ~mem_b(16'h0100 + a[9:0]));
		cmd(7, {9'h000, a[6:0]}, d, 1'b0);
		repeat (4) @(posedge core_clk);
		chk_pc(pair_value, {d, d});
		rd(16'h0040 + a[6:0], d, 1'b0, d);
		for (j = 4; j < 9; j++) begin
			seed = xs(seed);
			d = (i == 0) ? ((j % 5 == 1) ? 8'h80 : 8'hFF) : seed[15:8];
			c = seed[1] | (i == 0);
			cmd(j % 5, {12'h000, seed[19:16]}, d, c);
			case (j % 5)
			0: if (c) pc_m = pc_m + 16'h0002 + d[4:0];
			1: if (c) pc_m = pc_m + 16'h0002 + {{8{d[7]}}, d};
			2: pc_m = {12'h000, seed[19:16]};
			3: pc_m = {mem_b(16'hFFC1 + 2 * seed[19:16]), mem_b(16'hFFC0 + 2 * seed[19:16])};
			default: pc_m = 16'hFF00 + d;
			endcase
			repeat (5) @(posedge core_clk);
			chk_pc(pc_out, pc_m + 16'h0002);
		end
		$display("test %0d done", i);
	end
	seed = xs(seed);
	large_variant <= 1'b0; // smaller part: 32K rom, 1K ram
	a = 16'h0040 + seed[9:0];
	rd(16'h4000 + {2'h0, seed[29:16]}, 8'h00, 1'b0, ~mem_b(16'h4000 + {2'h0, seed[29:16]}));
	cmd(2, a, 8'h00, 1'b0);
	repeat (5) @(posedge core_clk);
	cmd(5, a, 8'h00, 1'b0);
	k = 0;
	while (reset_pin_oe_n !== 1'b0 && k < 10) begin
		@(posedge core_clk);
		#1;
		chk_byte({7'h00, opcode_valid}, 8'h00);
		k++;
	end
	chk_byte({5'h00, reset_pin_oe_n, reset_pin_out, core_reset}, 8'h01);
	large_variant <= 1'b1;
	boot;
	cmd(5, a, 8'h00, 1'b0);
	wait_v(0);
	chk_byte(opcode, mem_b(pc_m));
	$display("trap test done");
	give_verdict;
end
endmodule
bind cpu_address_map_and_fetch cpu_address_map_and_fetch_monitor #(.TRAP_CYCLES(TRAP_CYCLES)) mon (
	.core_clk(core_clk), .rst_n(rst_n), .fetch_req(fetch_req), .short_rel_jump(short_rel_jump),
	.byte_rel_jump(byte_rel_jump), .abs_jump(abs_jump), .cond_ok(cond_ok), .jump_disp(jump_disp),
	.jump_target(jump_target), .data_rd(data_rd), .pc_out(pc_out), .opcode_valid(opcode_valid),
	.data_valid(data_valid), .core_reset(core_reset), .reset_pin_out(reset_pin_out),
	.reset_pin_oe_n(reset_pin_oe_n));
